// File: rtl/jtpr_pkg.sv
package jtpr_pkg;

  // Register map
  localparam logic [31:0] ID_ADDR   = 32'h01B3_F008;
  localparam logic [31:0] STAT_ADDR = 32'h01B3_F010;
  localparam logic [31:0] CTRL_ADDR = 32'h01B3_F014;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam int          CTRL_QUIET_BIT = 0;

  // Identity word layout
  localparam int VAR_LSB  = 28;
  localparam int PART_LSB = 12;
  localparam int MFR_LSB  = 1;

  // Instruction register
  localparam int          IR_W        = 4;
  localparam logic [3:0]  IR_IDCODE   = 4'h1;
  localparam logic [3:0]  IR_BYPASS   = 4'hF;
  localparam logic [3:0]  IR_CAPTURE  = 4'h1;
  localparam int          DR_W        = 32;

  // Debug configuration pin code for boundary scan mode
  localparam logic [1:0]  CFG_SCAN    = 2'h0;
  localparam logic [1:0]  CFG_RST     = 2'h0;

  localparam int          SYNC_STAGES = 2;

  typedef enum logic [3:0] {
    TAP_RESET      = 4'b0000,
    TAP_IDLE       = 4'b0001,
    TAP_SEL_DR     = 4'b0010,
    TAP_CAPTURE_DR = 4'b0011,
    TAP_SHIFT_DR   = 4'b0100,
    TAP_EXIT1_DR   = 4'b0101,
    TAP_PAUSE_DR   = 4'b0110,
    TAP_EXIT2_DR   = 4'b0111,
    TAP_UPDATE_DR  = 4'b1000,
    TAP_SEL_IR     = 4'b1001,
    TAP_CAPTURE_IR = 4'b1010,
    TAP_SHIFT_IR   = 4'b1011,
    TAP_EXIT1_IR   = 4'b1100,
    TAP_PAUSE_IR   = 4'b1101,
    TAP_EXIT2_IR   = 4'b1110,
    TAP_UPDATE_IR  = 4'b1111
  } jtpr_tap_state_t;

  function automatic logic [31:0] jtpr_id_word(input logic [3:0]  variant,
                                               input logic [15:0] part,
                                               input logic [10:0] mfr);
    jtpr_id_word = {variant, part, mfr, 1'b1};
  endfunction : jtpr_id_word

endpackage : jtpr_pkg

// File: rtl/jtpr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module jtpr_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  // First stage feeds only the second stage
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule : jtpr_sync
`default_nettype wire

// File: rtl/jtpr_tap_fsm.sv
`timescale 1ns/1ps
`default_nettype none
module jtpr_tap_fsm (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  jtpr_tap_if.fsm   tap
);
  jtpr_pkg::jtpr_tap_state_t state_q;
  jtpr_pkg::jtpr_tap_state_t state_d;

  assign tap.state = state_q;

  always_comb begin
    case (state_q)
      jtpr_pkg::TAP_RESET:      state_d = tap.tms ? jtpr_pkg::TAP_RESET    : jtpr_pkg::TAP_IDLE;
      jtpr_pkg::TAP_IDLE:       state_d = tap.tms ? jtpr_pkg::TAP_SEL_DR   : jtpr_pkg::TAP_IDLE;
      jtpr_pkg::TAP_SEL_DR:     state_d = tap.tms ? jtpr_pkg::TAP_SEL_IR   : jtpr_pkg::TAP_CAPTURE_DR;
      jtpr_pkg::TAP_CAPTURE_DR: state_d = tap.tms ? jtpr_pkg::TAP_EXIT1_DR : jtpr_pkg::TAP_SHIFT_DR;
      jtpr_pkg::TAP_SHIFT_DR:   state_d = tap.tms ? jtpr_pkg::TAP_EXIT1_DR : jtpr_pkg::TAP_SHIFT_DR;
      jtpr_pkg::TAP_EXIT1_DR:   state_d = tap.tms ? jtpr_pkg::TAP_UPDATE_DR : jtpr_pkg::TAP_PAUSE_DR;
      jtpr_pkg::TAP_PAUSE_DR:   state_d = tap.tms ? jtpr_pkg::TAP_EXIT2_DR : jtpr_pkg::TAP_PAUSE_DR;
      jtpr_pkg::TAP_EXIT2_DR:   state_d = tap.tms ? jtpr_pkg::TAP_UPDATE_DR : jtpr_pkg::TAP_SHIFT_DR;
      jtpr_pkg::TAP_UPDATE_DR:  state_d = tap.tms ? jtpr_pkg::TAP_SEL_DR   : jtpr_pkg::TAP_IDLE;
      jtpr_pkg::TAP_SEL_IR:     state_d = tap.tms ? jtpr_pkg::TAP_RESET    : jtpr_pkg::TAP_CAPTURE_IR;
      jtpr_pkg::TAP_CAPTURE_IR: state_d = tap.tms ? jtpr_pkg::TAP_EXIT1_IR : jtpr_pkg::TAP_SHIFT_IR;
      jtpr_pkg::TAP_SHIFT_IR:   state_d = tap.tms ? jtpr_pkg::TAP_EXIT1_IR : jtpr_pkg::TAP_SHIFT_IR;
      jtpr_pkg::TAP_EXIT1_IR:   state_d = tap.tms ? jtpr_pkg::TAP_UPDATE_IR : jtpr_pkg::TAP_PAUSE_IR;
      jtpr_pkg::TAP_PAUSE_IR:   state_d = tap.tms ? jtpr_pkg::TAP_EXIT2_IR : jtpr_pkg::TAP_PAUSE_IR;
      jtpr_pkg::TAP_EXIT2_IR:   state_d = tap.tms ? jtpr_pkg::TAP_UPDATE_IR : jtpr_pkg::TAP_SHIFT_IR;
      jtpr_pkg::TAP_UPDATE_IR:  state_d = tap.tms ? jtpr_pkg::TAP_SEL_DR   : jtpr_pkg::TAP_IDLE;
      default:                  state_d = jtpr_pkg::TAP_RESET;
    endcase
  end

  // Test reset only acts on a sampled test clock edge
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= jtpr_pkg::TAP_RESET;
    end else if (tap.step) begin
      state_q <= tap.trst_n ? state_d : jtpr_pkg::TAP_RESET;
    end
  end

  a_tap_trst_reset: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (tap.step && !tap.trst_n) |=> (state_q == jtpr_pkg::TAP_RESET))
    else $error("Test reset did not force the reset state");

endmodule : jtpr_tap_fsm
`default_nettype wire

// File: rtl/jtpr_tap_if.sv
`timescale 1ns/1ps
`default_nettype none
interface jtpr_tap_if;
  logic                      step;
  logic                      tms;
  logic                      trst_n;
  jtpr_pkg::jtpr_tap_state_t state;

  modport fsm  (input step, input tms, input trst_n, output state);
  modport ctrl (output step, output tms, output trst_n, input state);
endinterface : jtpr_tap_if
`default_nettype wire

// File: rtl/jtpr_test_port.sv
// Notes on behaviour
// - Core reset clears the core; test reset separately clears test and emulation logic.
// - The core leaves reset on core reset release even with test reset held.
// - While test reset is held, test port and emulation stay reset, core unaffected.
// - Identity variant field shifts out correctly only after core reset release.
// - All other scan instructions work whatever the core reset state.
// - Test reset is synchronous, taken on test clock rising edges; clock must run.
// - Undriven test reset pin reads asserted through an internal pull-down.
// - After core reset release, test reset rising edge latches both config pins.
// - Latched config pins select boundary scan mode or emulation mode.
// - A read-only identity register sits at its fixed memory address.
// - Identity register holds a 32-bit word; writes change nothing.
// - Variant in top four bits, sixteen-bit part number, eleven-bit maker field.
// - Bit zero of the identity word always reads one.
// - Data in, mode select and test reset are sampled on test clock rise.
// - Test data out changes only after test clock falling edges.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module jtpr_test_port #(
  parameter logic [3:0]  ID_VARIANT = 4'h5,     // Arbitrary value
  parameter logic [15:0] ID_PART    = 16'h1234, // Arbitrary value
  parameter logic [10:0] ID_MFR     = 11'h2A5   // Arbitrary value
) (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        test_clock_i,
  input  wire logic        tms_i,
  input  wire logic        tdi_i,
  input  wire logic        trst_n_i,
  input  wire logic        trst_drv_i,
  input  wire logic        core_resetn_i,
  input  wire logic        debug_cfg_pin_hi_i,
  input  wire logic        debug_cfg_pin_lo_i,
  input  wire logic [31:0] reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  output logic             tdo_o,
  output logic             tdo_oe_n_o,
  output logic             core_in_reset_o,
  output logic             emu_in_reset_o,
  output logic             scan_mode_o,
  output logic             emu_mode_o
);

  // Pin conditioning
  logic [7:0] pins_s;
  logic       trst_s;
  logic       core_s;
  logic       tck_s;
  logic       tms_s;
  logic       tdi_s;
  logic [1:0] cfg_s;

  jtpr_sync #(
    .W (8)
  ) u_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .d_i      ({trst_drv_i, trst_n_i, core_resetn_i, test_clock_i, tms_i, tdi_i,
                debug_cfg_pin_hi_i, debug_cfg_pin_lo_i}),
    .q_o      (pins_s)
  );

  // All pins share one delay, so their relative timing survives
  // Undriven pin is pulled low, so reads as asserted
  assign trst_s = pins_s[7] & pins_s[6];
  assign core_s = pins_s[5];
  assign tck_s  = pins_s[4];
  assign tms_s  = pins_s[3];
  assign tdi_s  = pins_s[2];
  assign cfg_s  = pins_s[1:0];

  // Test clock edges
  logic tck_q;
  logic tck_rise;
  logic tck_fall;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tck_q <= 1'b0;
    end else begin
      tck_q <= tck_s;
    end
  end

  assign tck_rise = tck_s & ~tck_q;
  assign tck_fall = ~tck_s & tck_q;

  // Scan state machine
  jtpr_tap_if tap_bus ();
  jtpr_pkg::jtpr_tap_state_t state;

  assign tap_bus.step   = tck_rise;
  assign tap_bus.tms    = tms_s;
  assign tap_bus.trst_n = trst_s;
  assign state          = tap_bus.state;

  jtpr_tap_fsm u_fsm (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .tap      (tap_bus)
  );

  // Test reset as seen at test clock edges
  logic       trst_q;
  logic       trst_rise;
  logic [1:0] cfg_q;

  assign trst_rise = tck_rise & trst_s & ~trst_q;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      trst_q <= 1'b0;
    end else if (tck_rise) begin
      trst_q <= trst_s;
    end
  end

  // Config pins only count once the core is out of reset
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_q <= jtpr_pkg::CFG_RST;
    end else if (trst_rise && core_s) begin
      cfg_q <= cfg_s;
    end
  end

  // Identity words
  logic [31:0] id_word;
  logic [31:0] id_capture;
  logic [3:0]  cap_variant;

  assign id_word     = jtpr_pkg::jtpr_id_word(ID_VARIANT, ID_PART, ID_MFR);
  // Variant comes from core side logic and is invalid while it is in reset
  assign cap_variant = core_s ? ID_VARIANT : 4'h0;
  assign id_capture  = jtpr_pkg::jtpr_id_word(cap_variant, ID_PART, ID_MFR);

  // Instruction and data paths
  logic [jtpr_pkg::IR_W-1:0] ir_sh_q;
  logic [jtpr_pkg::IR_W-1:0] ir_q;
  logic [jtpr_pkg::DR_W-1:0] dr_q;
  logic                      sel_id;
  logic                      in_shift_dr;
  logic                      in_shift_ir;

  assign sel_id      = (ir_q == jtpr_pkg::IR_IDCODE);
  assign in_shift_dr = (state == jtpr_pkg::TAP_SHIFT_DR);
  assign in_shift_ir = (state == jtpr_pkg::TAP_SHIFT_IR);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ir_sh_q <= jtpr_pkg::IR_CAPTURE;
      ir_q    <= jtpr_pkg::IR_IDCODE;
    end else if (tck_rise) begin
      case (state)
        jtpr_pkg::TAP_RESET:      ir_q    <= jtpr_pkg::IR_IDCODE;
        jtpr_pkg::TAP_CAPTURE_IR: ir_sh_q <= jtpr_pkg::IR_CAPTURE;
        jtpr_pkg::TAP_SHIFT_IR:   ir_sh_q <= {tdi_s, ir_sh_q[jtpr_pkg::IR_W-1:1]};
        jtpr_pkg::TAP_UPDATE_IR:  ir_q    <= ir_sh_q;
        default:                  ir_q    <= ir_q;
      endcase
    end
  end

  // Any code but identity acts as bypass, free of core reset
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dr_q <= '0;
    end else if (tck_rise && state == jtpr_pkg::TAP_CAPTURE_DR) begin
      dr_q <= sel_id ? id_capture : '0;
    end else if (tck_rise && in_shift_dr) begin
      dr_q <= sel_id ? {tdi_s, dr_q[jtpr_pkg::DR_W-1:1]}
                     : {dr_q[jtpr_pkg::DR_W-1:1], tdi_s};
    end
  end

  // Output launch on the falling edge gives the controller half a period of setup
  logic quiet;
  logic tdo_bit;

  assign tdo_bit = in_shift_ir ? ir_sh_q[0] : dr_q[0];

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tdo_o      <= 1'b1;
      tdo_oe_n_o <= 1'b1;
    end else if (tck_fall) begin
      tdo_o      <= tdo_bit;
      tdo_oe_n_o <= ~((in_shift_dr | in_shift_ir) & ~quiet);
    end
  end

  // Reset and mode outputs
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      core_in_reset_o <= 1'b1;
      emu_in_reset_o  <= 1'b1;
      scan_mode_o     <= 1'b0;
      emu_mode_o      <= 1'b0;
    end else begin
      core_in_reset_o <= ~core_s;
      emu_in_reset_o  <= ~trst_q | (state == jtpr_pkg::TAP_RESET);
      scan_mode_o     <= (cfg_q == jtpr_pkg::CFG_SCAN);
      emu_mode_o      <= (cfg_q != jtpr_pkg::CFG_SCAN);
    end
  end

  // Register port
  logic [31:0] ctrl_q;
  logic [31:0] status;
  logic [31:0] rdata_d;
  logic        hit_id;
  logic        hit_stat;
  logic        hit_ctrl;

  assign hit_id   = (reg_addr_i == jtpr_pkg::ID_ADDR);
  assign hit_stat = (reg_addr_i == jtpr_pkg::STAT_ADDR);
  assign hit_ctrl = (reg_addr_i == jtpr_pkg::CTRL_ADDR);
  assign quiet    = ctrl_q[jtpr_pkg::CTRL_QUIET_BIT];
  assign status   = {22'h00_0000, cfg_q, scan_mode_o, emu_in_reset_o,
                     core_in_reset_o, trst_q, state};
  assign rdata_d  = !reg_rd_i ? 32'h0000_0000 :
                    hit_id    ? id_word :
                    hit_stat  ? status :
                    hit_ctrl  ? ctrl_q : 32'h0000_0000;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q <= jtpr_pkg::CTRL_RST;
    end else if (reg_wr_i && hit_ctrl) begin
      // Identity writes fall through and store nothing
      ctrl_q <= {31'h0000_0000, reg_wdata_i[jtpr_pkg::CTRL_QUIET_BIT]};
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else begin
      reg_rdata_o <= rdata_d;
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_id_read;
    reg_rd_i && hit_id;
  endsequence

  sequence s_trst_release;
    trst_rise && core_s;
  endsequence

  a_id_read_word: assert property (s_id_read |=> reg_rdata_o == id_word)
    else $error("Identity read returned a wrong word");

  a_id_field_layout: assert property (s_id_read |=>
    reg_rdata_o[31:jtpr_pkg::VAR_LSB] == ID_VARIANT &&
    reg_rdata_o[27:jtpr_pkg::PART_LSB] == ID_PART &&
    reg_rdata_o[11:jtpr_pkg::MFR_LSB] == ID_MFR)
    else $error("Identity fields misplaced");

  a_id_lsb_one: assert property (s_id_read |=> reg_rdata_o[0])
    else $error("Identity bit zero not one");

  a_id_write_ignored: assert property ((reg_wr_i && hit_id) ##[1:2] s_id_read |=>
    reg_rdata_o == id_word)
    else $error("Identity changed after write");

  a_core_reset_free: assert property (1'b1 |=> core_in_reset_o == !$past(core_s))
    else $error("Core reset output not following core reset");

  a_trst_holds_emu: assert property ((tck_rise && !trst_s) |->
    ##2 emu_in_reset_o ##1 emu_in_reset_o)
    else $error("Emulation logic left reset while test reset held");

  a_cfg_latch_edge: assert property (s_trst_release |=> cfg_q == $past(cfg_s))
    else $error("Config pins not latched at test reset release");

  a_mode_select: assert property (1'b1 |=>
    scan_mode_o == ($past(cfg_q) == jtpr_pkg::CFG_SCAN) && emu_mode_o == !scan_mode_o)
    else $error("Mode output does not match latched config");

  a_variant_gated: assert property ((tck_rise && state == jtpr_pkg::TAP_CAPTURE_DR &&
    sel_id && !core_s) |=> dr_q[31:jtpr_pkg::VAR_LSB] == 4'h0)
    else $error("Variant captured while core in reset");

  a_bypass_capture: assert property ((tck_rise && state == jtpr_pkg::TAP_CAPTURE_DR &&
    !sel_id) |=> dr_q[0] == 1'b0)
    else $error("Bypass capture not zero");

  a_ir_sample_rise: assert property ((tck_rise && in_shift_ir) |=>
    ir_sh_q[jtpr_pkg::IR_W-1] == $past(tdi_s))
    else $error("Instruction bit not sampled on rise");

  a_tdo_fall_only: assert property ($changed(tdo_o) |-> $past(tck_fall))
    else $error("Test data out changed off a falling edge");

endmodule : jtpr_test_port
`default_nettype wire

// File: verification/jtag_test_port_reset_id_tb.sv
`timescale 1ns/1ps
`default_nettype none
module jtag_test_port_reset_id_tb;
  localparam logic [3:0]  VAR_V    = 4'hA;     // Arbitrary value
  localparam logic [15:0] PART_V   = 16'h0C3D; // Arbitrary value
  localparam logic [10:0] MFR_V    = 11'h155;  // Arbitrary value
  localparam logic [31:0] ID_FULL  = {VAR_V, PART_V, MFR_V, 1'b1};
  localparam logic [31:0] ID_NOVAR = {4'h0, PART_V, MFR_V, 1'b1};
  localparam logic [31:0] UNMAPPED = 32'h01B3_F00C;
  localparam int          TIMEOUT  = 20000;

  logic        clk_i;
  logic        resetn_i;
  logic        core_resetn_i;
  logic        debug_cfg_pin_hi_i;
  logic        debug_cfg_pin_lo_i;
  logic [31:0] reg_addr_i;
  logic [31:0] reg_wdata_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic [31:0] reg_rdata_o;
  logic        test_clock, tms, tdi, trst_n, trst_drv;
  logic        tdo_o, tdo_oe_n_o, core_in_reset_o, emu_in_reset_o, scan_mode_o, emu_mode_o;
  int          mismatches;
  int          tests_run;
  int          cycles;

  jtpr_test_port #(.ID_VARIANT(VAR_V), .ID_PART(PART_V), .ID_MFR(MFR_V)) i_dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .test_clock_i(test_clock), .tms_i(tms), .tdi_i(tdi),
    .trst_n_i(trst_n), .trst_drv_i(trst_drv), .core_resetn_i(core_resetn_i),
    .debug_cfg_pin_hi_i(debug_cfg_pin_hi_i), .debug_cfg_pin_lo_i(debug_cfg_pin_lo_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .tdo_o(tdo_o), .tdo_oe_n_o(tdo_oe_n_o),
    .core_in_reset_o(core_in_reset_o), .emu_in_reset_o(emu_in_reset_o),
    .scan_mode_o(scan_mode_o), .emu_mode_o(emu_mode_o));

  jtpr_ctrl_model i_ctrl (
    .clk_i(clk_i), .tdo_i(tdo_o), .tdo_oe_n_i(tdo_oe_n_o), .test_clock_o(test_clock),
    .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n), .trst_drv_o(trst_drv));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic results;
    $display("checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT) begin
      mismatches++;
      results();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : reg_rd

  // From Idle through one DR or IR scan back to Idle, LSB first
  task automatic shift(input logic ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout, output logic oe_n);
    logic t, o;
    dout = '0;
    i_ctrl.tick(1'b1, 1'b0, t, o);
    if (ir) i_ctrl.tick(1'b1, 1'b0, t, o);
    i_ctrl.tick(1'b0, 1'b0, t, o);
    i_ctrl.tick(1'b0, 1'b0, t, o);
    for (int i = 0; i < n; i++) begin
      i_ctrl.tick(i == n - 1, din[i], t, oe_n);
      dout[i] = t;
    end
    i_ctrl.tick(1'b1, 1'b0, t, o);
    i_ctrl.tick(1'b0, 1'b0, t, o);
    i_ctrl.park();
  endtask : shift

  // Reset clocked through, then an actively driven release latches the pins once the core is out of reset
  task automatic tap_reset(input logic [1:0] cfg);
    logic t, o;
    @(posedge clk_i);
    {debug_cfg_pin_hi_i, debug_cfg_pin_lo_i} <= cfg;
    i_ctrl.trst_set(1'b1, 1'b0);
    repeat (3) i_ctrl.tick(1'b1, 1'b0, t, o);
    i_ctrl.park();
    i_ctrl.trst_set(1'b1, 1'b1);
    i_ctrl.tick(1'b0, 1'b0, t, o);
    i_ctrl.park();
    repeat (4) @(posedge clk_i);
    #1;
  endtask : tap_reset

  task automatic t_regs;
    logic [31:0] d;
    check("core_in_reset", core_in_reset_o, 1);
    check("emu_in_reset", emu_in_reset_o, 1);
    reg_rd(jtpr_pkg::ID_ADDR, d);
    check("identity", d, ID_FULL);
    check("identity bit0", d[0], 1);
    @(posedge clk_i);
    #1 check("rdata idle", reg_rdata_o, 0);
    reg_wr(jtpr_pkg::ID_ADDR, ~ID_FULL);
    reg_rd(jtpr_pkg::ID_ADDR, d);
    check("identity after write", d, ID_FULL);
    reg_rd(UNMAPPED, d);
    check("unmapped", d, 0);
    $display("test regs done");
  endtask : t_regs

  task automatic t_trst_sync;
    logic t, o;
    repeat (2) i_ctrl.tick(1'b1, 1'b0, t, o);
    i_ctrl.park();
    check("pulled-down reset", emu_in_reset_o, 1);
    tap_reset(2'h3);
    check("port active", emu_in_reset_o, 0);
    check("no latch in core reset", scan_mode_o, 1);
    i_ctrl.trst_set(1'b1, 1'b0);
    repeat (10) @(posedge clk_i);
    #1 check("reset needs clock", emu_in_reset_o, 0);
    i_ctrl.tick(1'b1, 1'b0, t, o);
    i_ctrl.park();
    #1 check("reset on clock", emu_in_reset_o, 1);
    tap_reset(2'h3);
    $display("test trst_sync done");
  endtask : t_trst_sync

  task automatic t_scan_core_low;
    logic [31:0] d;
    logic        oe;
    shift(1'b0, 32, 32'h0, d, oe);
    check("scan id in core reset", d, ID_NOVAR);
    check("tdo driven", oe, 0);
    shift(1'b1, 4, {28'h0, jtpr_pkg::IR_BYPASS}, d, oe);
    check("ir capture", d[3:0], jtpr_pkg::IR_CAPTURE);
    shift(1'b0, 8, 32'hA5, d, oe);
    check("bypass", d[7:0], 8'h4A);
    reg_wr(jtpr_pkg::CTRL_ADDR, 32'h1);
    reg_rd(jtpr_pkg::CTRL_ADDR, d);
    check("ctrl quiet", d[jtpr_pkg::CTRL_QUIET_BIT], 1);
    shift(1'b0, 8, 32'h0, d, oe);
    check("quiet tdo released", oe, 1);
    reg_wr(jtpr_pkg::CTRL_ADDR, 32'h0);
    $display("test scan_core_low done");
  endtask : t_scan_core_low

  task automatic t_boot;
    logic [1:0]  codes [4] = '{2'h1, 2'h0, 2'h3, 2'h2};
    logic [31:0] d;
    logic        t, o;
    i_ctrl.trst_set(1'b0, 1'b0);
    repeat (2) i_ctrl.tick(1'b1, 1'b0, t, o);
    @(posedge clk_i);
    core_resetn_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    #1 check("core boots", core_in_reset_o, 0);
    check("port held", emu_in_reset_o, 1);
    repeat (3) i_ctrl.tick(1'b0, 1'b1, t, o);
    i_ctrl.park();
    check("port still held", emu_in_reset_o, 1);
    check("core unaffected", core_in_reset_o, 0);
    foreach (codes[k]) begin
      tap_reset(codes[k]);
      check("scan mode", scan_mode_o, codes[k] == 2'h0);
      check("emulation mode", emu_mode_o, codes[k] != 2'h0);
    end
    shift(1'b0, 32, 32'h0, d, o);
    check("scan id core running", d, ID_FULL);
    reg_rd(jtpr_pkg::STAT_ADDR, d);
    check("status", d[9:0], {6'h21, jtpr_pkg::TAP_IDLE});
    check("tdo steady while high", i_ctrl.tdo_moved, 0);
    $display("test boot done");
  endtask : t_boot

  initial begin
    resetn_i           = 1'b0;
    core_resetn_i      = 1'b0;
    debug_cfg_pin_hi_i = 1'b0;
    debug_cfg_pin_lo_i = 1'b0;
    reg_addr_i         = '0;
    reg_wdata_i        = '0;
    reg_wr_i           = 1'b0;
    reg_rd_i           = 1'b0;
    mismatches         = 0;
    tests_run          = 0;
    cycles             = 0;
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    t_regs();
    t_trst_sync();
    t_scan_core_low();
    t_boot();
    results();
  end
endmodule : jtag_test_port_reset_id_tb
`default_nettype wire

// File: verification/jtpr_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module jtpr_ctrl_model (
  input  wire logic clk_i,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_n_i,
  output logic      test_clock_o,
  output logic      tms_o,
  output logic      tdi_o,
  output logic      trst_n_o,
  output logic      trst_drv_o
);
  int   tdo_moved;
  logic pin_tdo;

  // Released line shows the inverse of its last value, so a missed drive shows up
  assign pin_tdo = tdo_oe_n_i ? ~tdo_i : tdo_i;

  // Power-up: reset pin left undriven, so the pull-down holds it asserted
  initial begin
    test_clock_o = 1'b0;
    tms_o        = 1'b1;
    tdi_o        = 1'b0;
    trst_n_o     = 1'b0;
    trst_drv_o   = 1'b0;
    tdo_moved    = 0;
  end

  // One test clock period of 8 system clocks; pins change only at the fall
  task automatic tick(input logic tms, input logic tdi, output logic tdo, output logic oe_n);
    logic early;
    @(posedge clk_i);
    test_clock_o <= 1'b0;
    tms_o        <= tms;
    tdi_o        <= tdi;
    repeat (4) @(posedge clk_i);
    test_clock_o <= 1'b1;
    @(posedge clk_i);
    #1 early = pin_tdo;
    repeat (2) @(posedge clk_i);
    #1 tdo = pin_tdo;
    oe_n = tdo_oe_n_i;
    // Output must not move while the clock is high
    if (early !== tdo) tdo_moved++;
  endtask : tick

  // Clock stands still low between frames
  task automatic park;
    @(posedge clk_i);
    test_clock_o <= 1'b0;
  endtask : park

  // Undriven means the pin shows its pull-down level
  task automatic trst_set(input logic drv, input logic lvl);
    @(posedge clk_i);
    trst_drv_o <= drv;
    trst_n_o   <= drv & lvl;
  endtask : trst_set
endmodule : jtpr_ctrl_model
`default_nettype wire
